// ===== hdl/cpmbt_regs.vh
`ifndef CPMBT_REGS_VH
`define CPMBT_REGS_VH
// Register byte offsets
`define CPMBT_OFS_CTRL0 4'h0
`define CPMBT_OFS_CTRL1 4'h4
`define CPMBT_OFS_BTIME 4'h8
`define CPMBT_OFS_STAT 4'hc
// Control 0 fields
`define CPMBT_C0_SLPREQ 0
`define CPMBT_C0_SFTRST 1
`define CPMBT_C0_WAKEUP_IRQ_ENABLE 2
`define CPMBT_C0_TLINK 3
`define CPMBT_C0_SLPACK 4
`define CPMBT_C0_WUPFLG 5
// Control 1 fields
`define CPMBT_C1_CLKSEL 0
`define CPMBT_C1_WUPFILT 1
`define CPMBT_C1_TRIPLE 2
// Bit timing fields
`define CPMBT_BT_PRESC_LSB 0
`define CPMBT_BT_SJW_LSB 6
`define CPMBT_BT_SEG1_LSB 8
`define CPMBT_BT_SEG2_LSB 12
// Reset values
`define CPMBT_RST_SFTRST 1'b1
`define CPMBT_RST_BTIME 15'h0000
// Segment limits in quanta
`define CPMBT_SEG1_MIN 5'h04
`define CPMBT_SEG2_MIN 5'h02
// Counts: bus-off recovery, resync and wake filter length
`define CPMBT_RECOV_GROUPS 128
`define CPMBT_RECOV_BITS 11
`define CPMBT_SYNC_BITS 11
`define CPMBT_FILT_LEN 8
// Bus responses
`define CPMBT_RESP_OKAY 2'h0
`define CPMBT_RESP_SLVERR 2'h2
`endif

// ===== hdl/cpmbt_glitch_filter.v
`timescale 1ns/1ps
`include "cpmbt_regs.vh"
module cpmbt_glitch_filter #(
  parameter LEN = `CPMBT_FILT_LEN
) (
  input wire mclk,
  input wire sys_rst,
  input wire clkEn,
  input wire filtOn,
  input wire rxIn,
  output reg activity_ff
);
  reg [7:0] domCnt_ff;
  // Dominant must persist LEN cycles when filtering; short glitches never reach activity
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      domCnt_ff <= 8'h00;
      activity_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      if (rxIn)
        domCnt_ff <= 8'h00;
      else if (domCnt_ff != LEN[7:0])
        domCnt_ff <= domCnt_ff + 8'h01;
      activity_ff <= filtOn ? (~rxIn && domCnt_ff >= LEN[7:0] - 8'h01) : ~rxIn;
    end
  end
endmodule // cpmbt_glitch_filter

// ===== hdl/cpmbt_bit_timing.v
`timescale 1ns/1ps
`include "cpmbt_regs.vh"
module cpmbt_bit_timing (
  input wire mclk,
  input wire sys_rst,
  input wire run,
  input wire srcTick,
  input wire [5:0] prescDiv,
  input wire [3:0] seg1,
  input wire [2:0] seg2,
  input wire [1:0] sjw,
  input wire triple,
  input wire rxIn,
  output reg tqTick_ff,
  output reg samplePoint_ff,
  output reg bitEnd_ff,
  output reg rxBit_ff
);
  reg [5:0] presc_ff;
  reg [4:0] q_ff;
  reg [2:0] hold_ff;
  reg [1:0] hist_ff;
  reg rxPrev_ff;
  wire [4:0] s1Raw = {1'b0, seg1} + 5'h01;
  wire [4:0] s2Raw = {2'b00, seg2} + 5'h01;
  // Field is length minus one; short codes clamp to the least legal length
  wire [4:0] s1 = (s1Raw < `CPMBT_SEG1_MIN) ? `CPMBT_SEG1_MIN : s1Raw;
  wire [4:0] s2 = (s2Raw < `CPMBT_SEG2_MIN) ? `CPMBT_SEG2_MIN : s2Raw;
  wire [4:0] jw = {3'h0, sjw} + 5'h01;
  wire [4:0] last = s1 + s2;
  wire [4:0] rest = last - q_ff + 5'h01;
  wire tq = run && srcTick && (presc_ff == prescDiv);
  wire edgeSeen = rxPrev_ff && !rxIn;
  wire atSample = tq && hold_ff == 3'h0 && q_ff == s1;
  wire maj = (hist_ff[1] & hist_ff[0]) | (hist_ff[1] & rxIn) | (hist_ff[0] & rxIn);
  // Prescaler, quantum position and jump-width resync; all are cleared when run is low
  always @(posedge mclk)
  begin
    if (sys_rst || !run)
    begin
      presc_ff <= 6'h00;
      q_ff <= 5'h00;
      hold_ff <= 3'h0;
      hist_ff <= 2'h3;
      rxPrev_ff <= 1'b1;
      tqTick_ff <= 1'b0;
      samplePoint_ff <= 1'b0;
      bitEnd_ff <= 1'b0;
      rxBit_ff <= 1'b1;
    end
    else
    begin
      tqTick_ff <= tq;
      samplePoint_ff <= atSample;
      bitEnd_ff <= 1'b0;
      if (srcTick)
        presc_ff <= (presc_ff == prescDiv) ? 6'h00 : presc_ff + 6'h01;
      if (atSample)
        rxBit_ff <= triple ? maj : rxIn;
      if (tq)
      begin
        rxPrev_ff <= rxIn;
        hist_ff <= {hist_ff[0], rxIn};
        if (hold_ff != 3'h0)
          hold_ff <= hold_ff - 3'h1;
        else if (edgeSeen && q_ff != 5'h00 && q_ff <= s1)
        begin
          hold_ff <= (q_ff < jw) ? q_ff[2:0] : jw[2:0];
          q_ff <= q_ff + 5'h01;
        end
        else if (edgeSeen && q_ff > s1 && rest <= jw)
        begin
          q_ff <= 5'h00;
          bitEnd_ff <= 1'b1;
        end
        else if (edgeSeen && q_ff > s1)
          q_ff <= q_ff + jw;
        else if (q_ff >= last)
        begin
          q_ff <= 5'h00;
          bitEnd_ff <= 1'b1;
        end
        else
          q_ff <= q_ff + 5'h01;
      end
    end
  end
endmodule // cpmbt_bit_timing

// ===== hdl/cpmbt_top.v
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "cpmbt_regs.vh"
// Contract
// - Sleep and soft reset stop engine clocks; power-down stops all.
// - CPU stop gives power-down; else request/soft-reset bits pick the mode.
// - Wake-up interrupt raised only with sleep ack and wake enable set.
// - Sleep is entered only when neither transmitting nor receiving.
// - Sleep ack stays set for the whole time in sleep.
// - Transmit pin is recessive throughout sleep.
// - In sleep buffers stay usable; no copy and no abort happen.
// - Bus-off recovery count freezes in sleep and resumes afterwards.
// - Sleep ends on bus activity, sleep request clear or soft reset.
// - Clearing sleep request is ignored until sleep ack is set.
// - After wake-up wait eleven recessive bits before joining.
// - On wake-up release the deferred copy, aborts and transmissions.
// - Soft reset halts transfers at once; registers stay accessible.
// - Power-down aborts transfers, forces transmit recessive, blocks registers.
// - Bus activity in power-down wakes system; data ignored until resync.
// - During CPU wait the block stays fully active with interrupts.
// - Wake filter mode low-pass filters receive line during sleep.
// - One bit time timestamp pulse after every valid frame end.
// - Timestamp drives timer capture channel 0 only when link enabled.
// - Clock select picks oscillator or PLL; prescaler makes quantum clock.
// - Bit is sync quantum plus segment one 4-16 and segment two 2-8.
// - Jump width programmable from one to four quanta.
// - Sample at sample point; triple sampling ends at third sample.
module cpmbt_top #(
  parameter FILT_LEN = `CPMBT_FILT_LEN,
  parameter SYNC_BITS = `CPMBT_SYNC_BITS,
  parameter RECOV_BITS = `CPMBT_RECOV_BITS,
  parameter RECOV_GROUPS = `CPMBT_RECOV_GROUPS
) (
  input wire mclk,
  input wire sys_rst,
  input wire clkEn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire cpuStop,
  input wire txBusy,
  input wire rxBusy,
  input wire busOff,
  input wire frameValidEof,
  input wire engineTx,
  input wire oscTick,
  input wire pllTick,
  input wire canRxPin,
  output reg canTxPin_ff,
  output reg wakeIrq_ff,
  output wire systemWake,
  output reg engineClkEn_ff,
  output reg engineAbort_ff,
  output reg bgCopyHold_ff,
  output reg deferredGo_ff,
  output reg recoveryDone_ff,
  output reg timerCapture_ff,
  output wire tqTick,
  output wire samplePoint,
  output wire bitEnd,
  output wire rxBit
);
  localparam ST_NORM = 3'h0;
  localparam ST_SLREQ = 3'h1;
  localparam ST_SLEEP = 3'h2;
  localparam ST_SYNC = 3'h3;
  localparam ST_SRST = 3'h4;
  localparam ST_PDN = 3'h5;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg sleepReq_ff;
  reg softRst_ff;
  reg wakeup_irq_enable_ff;
  reg tLink_ff;
  reg wakeFlag_ff;
  reg clkSel_ff;
  reg filtMode_ff;
  reg triple_ff;
  reg [14:0] btime_ff;
  reg [3:0] syncCnt_ff;
  reg [3:0] recBit_ff;
  reg [7:0] recGrp_ff;
  reg tsPulse_ff;
  reg awHave_ff;
  reg wHave_ff;
  reg [3:0] awAddr_ff;
  reg [31:0] wData_ff;
  reg [3:0] wStrb_ff;
  wire busWake;
  wire sleepAck = (state_ff == ST_SLEEP);
  wire running = (state_ff == ST_NORM) || (state_ff == ST_SLREQ);
  wire timingRun = clkEn && (running || state_ff == ST_SYNC);
  wire srcTick = clkSel_ff ? pllTick : oscTick;

  // Wake detector runs on the register clock so it still works in sleep
  cpmbt_glitch_filter #(
    .LEN(FILT_LEN)
  ) u_filter (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .filtOn(filtMode_ff),
    .rxIn(canRxPin),
    .activity_ff(busWake)
  );

  // Quantum and bit clock only in the modes that need the bus
  cpmbt_bit_timing u_timing (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(timingRun),
    .srcTick(srcTick),
    .prescDiv(btime_ff[`CPMBT_BT_PRESC_LSB +: 6]),
    .seg1(btime_ff[`CPMBT_BT_SEG1_LSB +: 4]),
    .seg2(btime_ff[`CPMBT_BT_SEG2_LSB +: 3]),
    .sjw(btime_ff[`CPMBT_BT_SJW_LSB +: 2]),
    .triple(triple_ff),
    .rxIn(canRxPin),
    .tqTick_ff(tqTick),
    .samplePoint_ff(samplePoint),
    .bitEnd_ff(bitEnd),
    .rxBit_ff(rxBit)
  );

  // Mode selection; CPU stop overrides every register bit
  always @*
  begin
    nxt_state = state_ff;
    if (cpuStop)
      nxt_state = ST_PDN;
    else if (softRst_ff)
      nxt_state = ST_SRST;
    else
    begin
      case (state_ff)
        ST_PDN: nxt_state = ST_SYNC;
        ST_SRST: nxt_state = ST_SYNC;
        ST_NORM: if (sleepReq_ff) nxt_state = ST_SLREQ;
        ST_SLREQ:
          if (!sleepReq_ff)
            nxt_state = ST_NORM;
          else if (!txBusy && !rxBusy)
            nxt_state = ST_SLEEP;
        ST_SLEEP: if (busWake || !sleepReq_ff) nxt_state = ST_SYNC;
        ST_SYNC:
          if (samplePoint && rxBit && syncCnt_ff >= SYNC_BITS[3:0] - 4'h1)
            nxt_state = ST_NORM;
        default: nxt_state = ST_SRST;
      endcase
    end
  end

  // Power-down wake request leaves even with the register clock frozen
  assign systemWake = (state_ff == ST_PDN) && !canRxPin;

  // Mode register, resync counter and mode-derived outputs
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_ff <= ST_SRST;
      syncCnt_ff <= 4'h0;
      canTxPin_ff <= 1'b1;
      engineClkEn_ff <= 1'b0;
      engineAbort_ff <= 1'b0;
      bgCopyHold_ff <= 1'b0;
      deferredGo_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      state_ff <= nxt_state;
      if (state_ff != ST_SYNC || (samplePoint && !rxBit))
        syncCnt_ff <= 4'h0;
      else if (samplePoint)
        syncCnt_ff <= syncCnt_ff + 4'h1;
      // Engine sees a clock only while online; wait mode leaves it running
      engineClkEn_ff <= (nxt_state == ST_NORM) || (nxt_state == ST_SLREQ);
      canTxPin_ff <= ((nxt_state == ST_NORM) || (nxt_state == ST_SLREQ)) ? engineTx : 1'b1;
      engineAbort_ff <= running && (nxt_state == ST_SRST || nxt_state == ST_PDN);
      bgCopyHold_ff <= (nxt_state == ST_SLEEP);
      deferredGo_ff <= sleepAck && (nxt_state != ST_SLEEP);
    end
  end

  // Bus-off recovery: 128 runs of 11 recessive bits, counted only online
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      recBit_ff <= 4'h0;
      recGrp_ff <= 8'h00;
      recoveryDone_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      recoveryDone_ff <= 1'b0;
      if (!busOff)
      begin
        recBit_ff <= 4'h0;
        recGrp_ff <= 8'h00;
      end
      else if (running && samplePoint)
      begin
        if (!rxBit)
          recBit_ff <= 4'h0;
        else if (recBit_ff == RECOV_BITS[3:0] - 4'h1)
        begin
          recBit_ff <= 4'h0;
          if (recGrp_ff == RECOV_GROUPS[7:0] - 8'h01)
          begin
            recGrp_ff <= 8'h00;
            recoveryDone_ff <= 1'b1;
          end
          else
            recGrp_ff <= recGrp_ff + 8'h01;
        end
        else
          recBit_ff <= recBit_ff + 4'h1;
      end
    end
  end

  // Timestamp: set at valid end of frame, dropped at the next bit boundary
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tsPulse_ff <= 1'b0;
      timerCapture_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      if (frameValidEof && running)
        tsPulse_ff <= 1'b1;
      else if (bitEnd)
        tsPulse_ff <= 1'b0;
      timerCapture_ff <= ((frameValidEof && running) || (tsPulse_ff && !bitEnd)) && tLink_ff;
    end
  end

  // Bus slave: one write and one read at a time, address and data in any order
  assign s_axi_awready = !awHave_ff && !s_axi_bvalid;
  assign s_axi_wready = !wHave_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire wrGo = awHave_ff && wHave_ff && !s_axi_bvalid;
  wire pdn = (state_ff == ST_PDN);
  wire wrC0 = wrGo && !pdn && awAddr_ff == `CPMBT_OFS_CTRL0 && wStrb_ff[0];
  wire wrC1 = wrGo && !pdn && awAddr_ff == `CPMBT_OFS_CTRL1 && wStrb_ff[0];
  wire wrBt = wrGo && !pdn && awAddr_ff == `CPMBT_OFS_BTIME;
  wire wrMap = awAddr_ff == `CPMBT_OFS_CTRL0 || awAddr_ff == `CPMBT_OFS_CTRL1 ||
    awAddr_ff == `CPMBT_OFS_BTIME || awAddr_ff == `CPMBT_OFS_STAT;
  wire wakeEvt = sleepAck && wakeup_irq_enable_ff && busWake;

  // Write channel capture and response
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
      awAddr_ff <= 4'h0;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CPMBT_RESP_OKAY;
    end
    else if (clkEn)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_ff <= 1'b1;
        awAddr_ff <= {s_axi_awaddr[3:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (wrGo)
      begin
        awHave_ff <= 1'b0;
        wHave_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (pdn || !wrMap) ? `CPMBT_RESP_SLVERR : `CPMBT_RESP_OKAY;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Control bits; hardware events win over software clears
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sleepReq_ff <= 1'b0;
      softRst_ff <= `CPMBT_RST_SFTRST;
      wakeup_irq_enable_ff <= 1'b0;
      tLink_ff <= 1'b0;
      wakeFlag_ff <= 1'b0;
      clkSel_ff <= 1'b0;
      filtMode_ff <= 1'b0;
      triple_ff <= 1'b0;
      btime_ff <= `CPMBT_RST_BTIME;
      wakeIrq_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      if (wrC0)
      begin
        softRst_ff <= wData_ff[`CPMBT_C0_SFTRST];
        wakeup_irq_enable_ff <= wData_ff[`CPMBT_C0_WAKEUP_IRQ_ENABLE];
        tLink_ff <= wData_ff[`CPMBT_C0_TLINK];
        if (wData_ff[`CPMBT_C0_SLPREQ] || sleepAck)
          sleepReq_ff <= wData_ff[`CPMBT_C0_SLPREQ];
      end
      // Bus wake withdraws the request so the block does not fall asleep again
      if (sleepAck && busWake)
        sleepReq_ff <= 1'b0;
      if (wakeEvt)
        wakeFlag_ff <= 1'b1;
      else if (wrC0 && wData_ff[`CPMBT_C0_WUPFLG])
        wakeFlag_ff <= 1'b0;
      wakeIrq_ff <= (wakeFlag_ff || wakeEvt) && wakeup_irq_enable_ff;
      if (wrC1)
      begin
        clkSel_ff <= wData_ff[`CPMBT_C1_CLKSEL];
        filtMode_ff <= wData_ff[`CPMBT_C1_WUPFILT];
        triple_ff <= wData_ff[`CPMBT_C1_TRIPLE];
      end
      if (wrBt && wStrb_ff[0])
        btime_ff[7:0] <= wData_ff[7:0];
      if (wrBt && wStrb_ff[1])
        btime_ff[14:8] <= wData_ff[14:8];
    end
  end

  // Read channel; status shows mode and recovery progress
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CPMBT_RESP_OKAY;
    end
    else if (clkEn)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CPMBT_RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        if (pdn)
          s_axi_rresp <= `CPMBT_RESP_SLVERR;
        else if ({s_axi_araddr[3:2], 2'h0} == `CPMBT_OFS_CTRL0)
          s_axi_rdata <= {26'h0, wakeFlag_ff, sleepAck, tLink_ff, wakeup_irq_enable_ff, softRst_ff, sleepReq_ff};
        else if ({s_axi_araddr[3:2], 2'h0} == `CPMBT_OFS_CTRL1)
          s_axi_rdata <= {29'h0, triple_ff, filtMode_ff, clkSel_ff};
        else if ({s_axi_araddr[3:2], 2'h0} == `CPMBT_OFS_BTIME)
          s_axi_rdata <= {17'h0, btime_ff};
        else if ({s_axi_araddr[3:2], 2'h0} == `CPMBT_OFS_STAT)
          s_axi_rdata <= {16'h0, recGrp_ff, recBit_ff, busOff, state_ff};
        else
          s_axi_rresp <= `CPMBT_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // cpmbt_top

// ===== sim/cpmbt_checker.sv
`timescale 1ns/1ps
module cpmbt_checker (
  input wire mclk,
  input wire sys_rst,
  input wire clkEn,
  input wire cpuStop,
  input wire canRxPin,
  input wire canTxPin_ff,
  input wire systemWake,
  input wire engineClkEn_ff,
  input wire engineAbort_ff,
  input wire bgCopyHold_ff,
  input wire deferredGo_ff,
  input wire samplePoint,
  input wire bitEnd,
  input wire rxBit
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Sleep state pins: recessive line, engine unclocked
  property p_sleepTx; bgCopyHold_ff |-> canTxPin_ff; endproperty
  a_sleepTx: assert property (p_sleepTx) else $error("tx dominant in sleep");
  property p_sleepClk; bgCopyHold_ff |-> !engineClkEn_ff; endproperty
  a_sleepClk: assert property (p_sleepClk) else $error("engine clocked in sleep");
  // One edge of latency from cpuStop to the outputs, so three samples suffice
  property p_pdOut; (cpuStop && clkEn)[*3] |-> canTxPin_ff && !engineClkEn_ff; endproperty
  a_pdOut: assert property (p_pdOut) else $error("power-down outputs wrong");
  property p_wakeRx; systemWake |-> !canRxPin; endproperty
  a_wakeRx: assert property (p_wakeRx) else $error("wake without bus activity");
  property p_wakeTx; systemWake |-> canTxPin_ff; endproperty
  a_wakeTx: assert property (p_wakeTx) else $error("tx dominant in power-down");
  // Strobes last one enabled cycle; a frozen clock enable may stretch them
  property p_abort; engineAbort_ff && clkEn |=> !engineAbort_ff; endproperty
  a_abort: assert property (p_abort) else $error("abort pulse too long");
  property p_defer; deferredGo_ff && clkEn |=> !deferredGo_ff; endproperty
  a_defer: assert property (p_defer) else $error("deferred pulse too long");
  // Second segment is at least two quanta, so the two never meet
  property p_spEnd; samplePoint |-> !bitEnd; endproperty
  a_spEnd: assert property (p_spEnd) else $error("sample point at bit end");
  property p_rxBit; $changed(rxBit) |-> samplePoint || $past(samplePoint); endproperty
  a_rxBit: assert property (p_rxBit) else $error("rx bit moved off sample point");
endmodule // cpmbt_checker

bind cpmbt_top cpmbt_checker cpmbt_checker_inst (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn), .cpuStop(cpuStop),
  .canRxPin(canRxPin), .canTxPin_ff(canTxPin_ff), .systemWake(systemWake), .engineClkEn_ff(engineClkEn_ff),
  .engineAbort_ff(engineAbort_ff), .bgCopyHold_ff(bgCopyHold_ff), .deferredGo_ff(deferredGo_ff),
  .samplePoint(samplePoint), .bitEnd(bitEnd), .rxBit(rxBit));

// ===== sim/cpmbt_can_node.sv
`timescale 1ns/1ps
module cpmbt_can_node (
  input wire mclk,
  input wire go,
  input wire [7:0] len,
  output reg canRxPin
);
  reg [7:0] left;
  initial
  begin
    canRxPin = 1'b1;
    left = 8'h00;
  end
  // Dominant burst of len cycles; termination returns the bus to recessive
  always @(posedge mclk)
  begin
    if (go)
    begin
      left <= len;
      canRxPin <= 1'b0;
    end
    else if (left > 8'h01)
      left <= left - 8'h01;
    else
    begin
      left <= 8'h00;
      canRxPin <= 1'b1;
    end
  end
endmodule // cpmbt_can_node

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg mclk, sysRst, clkEn, awvalid, wvalid, bready, arvalid, rready, cpuStop, txBusy, rxBusy, busOff, fve;
  reg engineTx, oscTick, pllTick, go;
  reg [3:0] awaddr, araddr, wstrb;
  reg [31:0] wdata, d;
  reg [7:0] len;
  reg [1:0] rs, jw;
  reg [5:0] p;
  reg [3:0] s1;
  reg [2:0] s2;
  wire awready, wready, bvalid, arready, rvalid, canRxPin, canTx, wakeIrq, sysWake, engClk, engAbort, bgHold;
  wire defGo, recovDone, tCap, tqTick, samplePoint, bitEnd, rxBit;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer failures, nChecks, cyc, lastBe, lastSp, period, spGap, nBe, dgSeen, abSeen, i, t, e;
  cpmbt_top #(.FILT_LEN(2)) cpmbt_top_inst (.mclk(mclk), .sys_rst(sysRst), .clkEn(clkEn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpuStop(cpuStop),
    .txBusy(txBusy), .rxBusy(rxBusy), .busOff(busOff), .frameValidEof(fve), .engineTx(engineTx),
    .oscTick(oscTick), .pllTick(pllTick), .canRxPin(canRxPin), .canTxPin_ff(canTx), .wakeIrq_ff(wakeIrq),
    .systemWake(sysWake), .engineClkEn_ff(engClk), .engineAbort_ff(engAbort), .bgCopyHold_ff(bgHold),
    .deferredGo_ff(defGo), .recoveryDone_ff(recovDone), .timerCapture_ff(tCap), .tqTick(tqTick),
    .samplePoint(samplePoint), .bitEnd(bitEnd), .rxBit(rxBit));
  cpmbt_can_node cpmbt_can_node_inst (.mclk(mclk), .go(go), .len(len), .canRxPin(canRxPin));
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = !mclk;
  end
  // Bit period and sample-to-end gap, measured from pre-edge values
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    pllTick <= !pllTick;
    if (defGo) dgSeen = 1;
    if (engAbort) abSeen = 1;
    if (samplePoint) lastSp <= cyc;
    if (bitEnd)
    begin
      period <= cyc - lastBe;
      spGap <= cyc - lastSp;
      lastBe <= cyc;
      nBe <= nBe + 1;
    end
  end
  task chk(input [63:0] nm, input [31:0] ex, input [31:0] got);
    begin
      nChecks = nChecks + 1;
      if (got !== ex)
      begin
        failures = failures + 1;
        $display("mismatch %0s exp %h got %h", nm, ex, got);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d failures %0d", nChecks, failures);
      if (failures == 0 && nChecks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Handshakes are judged 1 ns after the previous edge, so the edge's own updates never race
  task automatic wr(input [3:0] a, input [31:0] v);
    reg aw, w, b;
    integer k;
    begin
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b = 1'b0;
      for (k = 0; k < 100 && !b; k = k + 1)
      begin
        #1;
        aw = awvalid && awready;
        w = wvalid && wready;
        b = bvalid;
        if (b) rs = bresp;
        @(posedge mclk);
        if (aw) awvalid <= 1'b0;
        if (w) wvalid <= 1'b0;
      end
      bready <= 1'b0;
    end
  endtask
  task automatic rd(input [3:0] a);
    reg ar, r;
    integer k;
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r = 1'b0;
      for (k = 0; k < 100 && !r; k = k + 1)
      begin
        #1;
        ar = arvalid && arready;
        r = rvalid;
        if (r) d = rdata;
        if (r) rs = rresp;
        @(posedge mclk);
        if (ar) arvalid <= 1'b0;
      end
      rready <= 1'b0;
    end
  endtask
  task waitBits(input integer n);
    begin
      e = nBe + n;
      for (t = 0; t < 9000 && nBe < e; t = t + 1)
        @(posedge mclk);
    end
  endtask
  task pulse(input [7:0] n);
    begin
      go <= 1'b1;
      len <= n;
      @(posedge mclk);
      go <= 1'b0;
    end
  endtask
  // Expected bit length in quanta with the clamped segment lengths
  function integer quanta(input [3:0] f1, input [2:0] f2);
    quanta = 1 + ((f1 < 4'h3) ? 4 : f1 + 1) + ((f2 == 3'h0) ? 2 : f2 + 1);
  endfunction
  initial
  begin
    #(25 * 60000);
    failures = failures + 1;
    results;
  end
  initial
  begin
    {failures, nChecks, cyc, lastBe, lastSp, period, spGap, nBe, dgSeen, abSeen} = 0;
    {awvalid, wvalid, bready, arvalid, rready, cpuStop, txBusy, rxBusy, busOff, fve, engineTx, go, pllTick} = 0;
    {sysRst, clkEn, oscTick} = 3'h7;
    {awaddr, araddr, wdata, len} = 0;
    wstrb = 4'hf;
    d = $urandom(32'hac2842b6);
    repeat (3) @(posedge mclk);
    sysRst <= 1'b0;
    @(posedge mclk);
    rd(4'h0);
    chk("ctrl0", 32'h2, d & 32'h3f);
    rd(4'hc);
    chk("mode", 32'h4, d & 32'h7);
    wr(4'h0, 32'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
      p = $urandom % 4;
      s1 = (i == 0) ? 4'h2 : $urandom;
      s2 = (i == 0) ? 3'h0 : $urandom;
      // Jump width held in a 2-bit variable so the concatenation keeps the segment fields
      jw = $urandom;
      wr(4'h8, {17'h0, s2, s1, jw, p});
      wr(4'h4, (i == 3) ? 32'h1 : 32'h0);
      waitBits(3);
      chk("period", (p + 1) * quanta(s1, s2) * ((i == 3) ? 2 : 1), period);
      chk("spgap", (p + 1) * (quanta(s1, s2) - 1 - ((s1 < 4'h3) ? 4 : s1 + 1)) * ((i == 3) ? 2 : 1), spGap);
    end
    chk("rxbit", 1, rxBit);
    rd(4'hc);
    chk("mode", 32'h0, d & 32'h7);
    $display("test timing done");
    wr(4'h4, 32'h0);
    txBusy <= 1'b1;
    wr(4'h0, 32'h5);
    wr(4'h0, 32'h4);
    rd(4'h0);
    chk("slp tx", 32'h01, d & 32'h11);
    txBusy <= 1'b0;
    rxBusy <= 1'b1;
    repeat (20) @(posedge mclk);
    rd(4'h0);
    chk("slp rx", 32'h01, d & 32'h11);
    rxBusy <= 1'b0;
    repeat (20) @(posedge mclk);
    rd(4'h0);
    chk("slp ack", 32'h11, d & 32'h11);
    chk("hold", 1, bgHold);
    chk("engclk", 0, engClk);
    chk("txrec", 1, canTx);
    dgSeen = 0;
    pulse(8'd30);
    repeat (40) @(posedge mclk);
    #1;
    chk("defgo", 1, dgSeen);
    chk("wakeirq", 1, wakeIrq);
    rd(4'h0);
    chk("wake", 32'h20, d & 32'h31);
    waitBits(8);
    chk("resync", 1, canTx);
    waitBits(6);
    chk("online", 0, canTx);
    wr(4'h0, 32'h24);
    #1;
    chk("irqclr", 0, wakeIrq);
    $display("test sleep done");
    wr(4'h4, 32'h2);
    wr(4'h0, 32'h5);
    repeat (20) @(posedge mclk);
    pulse(8'd1);
    repeat (20) @(posedge mclk);
    rd(4'h0);
    chk("glitch", 32'h10, d & 32'h30);
    wr(4'h0, 32'h4);
    rd(4'h0);
    chk("clrreq", 32'h00, d & 32'h11);
    waitBits(13);
    abSeen = 0;
    wr(4'h0, 32'h2);
    rd(4'hc);
    chk("srmode", 32'h4, d & 32'h7);
    chk("srresp", 0, rs);
    chk("srabort", 1, abSeen);
    wr(4'h0, 32'h8);
    waitBits(13);
    fve <= 1'b1;
    @(posedge mclk);
    fve <= 1'b0;
    #1;
    chk("tstamp", 1, tCap);
    waitBits(2);
    #1;
    chk("tsend", 0, tCap);
    wr(4'h0, 32'h0);
    fve <= 1'b1;
    @(posedge mclk);
    fve <= 1'b0;
    #1;
    chk("nolink", 0, tCap);
    $display("test link done");
    abSeen = 0;
    engineTx <= 1'b0;
    cpuStop <= 1'b1;
    repeat (5) @(posedge mclk);
    rd(4'h0);
    chk("pdresp", 2, rs);
    chk("pdabort", 1, abSeen);
    pulse(8'd20);
    repeat (3) @(posedge mclk);
    #1;
    chk("syswake", 1, sysWake);
    $display("test powerdown done");
    results;
  end
endmodule // testbench
